// File: verilog/dual_timer_pkg.sv
/*
  Package for the dual timer/counter block: register addresses, bit positions,
  reset values, mode codes and the peripheral cycle length.
  Assumes an 8-bit special function register port from the processor core.
*/
package dual_timer_pkg;
  localparam logic [7:0] ADDR_CONTROL  = 8'h88;
  localparam logic [7:0] ADDR_MODE     = 8'h89;
  localparam logic [7:0] ADDR_A_LOW    = 8'h8a;
  localparam logic [7:0] ADDR_B_LOW    = 8'h8b;
  localparam logic [7:0] ADDR_A_HIGH   = 8'h8c;
  localparam logic [7:0] ADDR_B_HIGH   = 8'h8d;
  localparam logic [7:0] RESET_VALUE   = 8'h00;
  // Control register bit positions
  localparam int BIT_B_OVF    = 7;
  localparam int BIT_B_RUN    = 6;
  localparam int BIT_A_OVF    = 5;
  localparam int BIT_A_RUN    = 4;
  localparam int BIT_B_EDGE   = 3;
  localparam int BIT_B_TRIG   = 2;
  localparam int BIT_A_EDGE   = 1;
  localparam int BIT_A_TRIG   = 0;
  // Mode register: each unit owns a nibble; B at 4, A at 0
  localparam int NIB_B        = 4;
  localparam int NIB_A        = 0;
  localparam int OFS_GATE     = 3;
  localparam int OFS_SRC      = 2;
  localparam int OFS_MODE     = 0;
  localparam logic [1:0] MODE_PRESCALE = 2'h0;
  localparam logic [1:0] MODE_CASCADE  = 2'h1;
  localparam logic [1:0] MODE_RELOAD   = 2'h2;
  localparam logic [1:0] MODE_SPLIT    = 2'h3;
  localparam logic [4:0] PRESCALE_MAX  = 5'h1f;
  // Peripheral cycle: six peripheral clock periods
  localparam int PER_CYCLE_CLKS = 6;
  localparam logic [2:0] PER_CYCLE_LAST = 3'(PER_CYCLE_CLKS - 1);
endpackage : dual_timer_pkg

// File: verilog/timer_count_unit.sv
/*
  One timer unit: low and high count bytes with modes 0..3.
  Assumes tick enables come from the parent; software writes win over counting.
*/
`timescale 1ns/1ps
module timer_count_unit (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       lowTick,
  input  wire logic       highTick,
  input  wire logic [1:0] mode,
  input  wire logic       splitAllowed,
  input  wire logic       wrLow,
  input  wire logic       wrHigh,
  input  wire logic [7:0] wrData,
  output logic      [7:0] countLow,
  output logic      [7:0] countHigh,
  output logic            lowOverflow,
  output logic            highOverflow
);
  logic [7:0] low_ff;
  logic [7:0] high_ff;
  logic [7:0] nxt_low;
  logic [7:0] nxt_high;

  assign countLow  = low_ff;
  assign countHigh = high_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Next count per mode
  always_comb
  begin
    nxt_low      = low_ff;
    nxt_high     = high_ff;
    lowOverflow  = 1'b0;
    highOverflow = 1'b0;
    case (mode)
      dual_timer_pkg::MODE_PRESCALE:
      begin
        if (lowTick)
        begin
          nxt_low[4:0] = low_ff[4:0] + 5'h01;
          if (low_ff[4:0] == dual_timer_pkg::PRESCALE_MAX)
          begin
            nxt_high = high_ff + 8'h01;
            highOverflow = (high_ff == 8'hff);
          end
        end
      end
      dual_timer_pkg::MODE_CASCADE:
      begin
        if (lowTick)
        begin
          nxt_low = low_ff + 8'h01;
          if (low_ff == 8'hff)
          begin
            nxt_high = high_ff + 8'h01;
            highOverflow = (high_ff == 8'hff);
          end
        end
      end
      dual_timer_pkg::MODE_RELOAD:
      begin
        if (lowTick)
        begin
          if (low_ff == 8'hff)
          begin
            nxt_low = high_ff;
            highOverflow = 1'b1;
          end
          else
          begin
            nxt_low = low_ff + 8'h01;
          end
        end
      end
      dual_timer_pkg::MODE_SPLIT:
      begin
        if (splitAllowed)
        begin
          if (lowTick)
          begin
            nxt_low = low_ff + 8'h01;
            lowOverflow = (low_ff == 8'hff);
          end
          if (highTick)
          begin
            nxt_high = high_ff + 8'h01;
            highOverflow = (high_ff == 8'hff);
          end
        end
      end
      default:
      begin
        nxt_low = low_ff;
      end
    endcase
    if (wrLow)
    begin
      nxt_low = wrData;
    end
    if (wrHigh)
    begin
      nxt_high = wrData;
    end
  end

  // Count bytes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      low_ff  <= dual_timer_pkg::RESET_VALUE;
      high_ff <= dual_timer_pkg::RESET_VALUE;
    end
    else
    begin
      low_ff  <= nxt_low;
      high_ff <= nxt_high;
    end
  end
endmodule : timer_count_unit

// File: verilog/dual_timer_counter_ctrl.sv
/*
  Dual timer/counter with shared control and mode registers on an SFR port.
  Assumes a synchronous SFR port, synchronous pins and a core that pulses
  vector acknowledges when it enters the timer or external interrupt routine.
  The unit and global interrupt enables arrive as plain levels from the core,
  and the core stops a unit before it reads a count pair that must agree.
*/
// Notes on behaviour
// - Overflow sets unit flag; control writes can set it too
// - Vectoring to routine clears overflow flag
// - Timer interrupt needs unit enable and global enable
// - Run bits: B at 6, A at 4
// - Overflow flags: B at 7, A at 5
// - Edge flags bits 3,1 set; edge clears
// - Trigger bits 2,0: low level or falling
// - Gate bit makes pin high required
// - Source bit picks clock or pin falls
// - Mode 0: 8-bit high, 5-bit prescaler
// - Mode 1: 16-bit cascade counter
// - Mode 2: low byte reloads from high
// - Timer B mode 3 holds count
// - Timer A mode 3 splits, borrows B bits
// - All six registers reset to zero
// - Count exposed as high, low bytes
// - Timer increments once per six clocks
// - Counter samples pin per cycle, falls
// - Mode 0 prescaler modulo 32
// - Cascade low carry bumps high; high sets flag
`timescale 1ns/1ps
module dual_timer_counter_ctrl (
  input  wire logic       clk,
  input  wire logic       rst,
  // Special function register port
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrite,
  input  wire logic       sfrRead,
  input  wire logic [7:0] sfrWrData,
  output logic      [7:0] sfrRdData,
  output logic            sfrHit,
  // Interrupt and count pins
  input  wire logic       ext_irq_a_pin,
  input  wire logic       ext_irq_b_pin,
  input  wire logic       count_input_a,
  input  wire logic       count_input_b,
  // Interrupt interface to the core
  input  wire logic       global_irq_enable,
  input  wire logic       timer_a_irq_enable,
  input  wire logic       timer_b_irq_enable,
  input  wire logic       timerAVectorAck,
  input  wire logic       timerBVectorAck,
  input  wire logic       extAVectorAck,
  input  wire logic       extBVectorAck,
  output logic            timerAIrq,
  output logic            timerBIrq,
  output logic            extAIrq,
  output logic            extBIrq
);
  // Registers and their next values
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [7:0] mode_ff;
  logic [7:0] nxt_mode;
  logic [2:0] div_ff;
  logic [2:0] nxt_div;
  logic [1:0] cntSample_ff;
  logic [1:0] nxt_cntSample;
  logic [1:0] irqSample_ff;
  logic [1:0] nxt_irqSample;
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;
  // Per-unit and decode wiring
  logic       perTick;
  logic [1:0] lowTick;
  logic [1:0] highTick;
  logic [1:0] lowOvf;
  logic [1:0] highOvf;
  logic [1:0] wrLow;
  logic [1:0] wrHigh;
  logic [7:0] cntLow  [2];
  logic [7:0] cntHigh [2];
  logic [1:0] pinCount;
  logic [1:0] pinIrq;
  logic [1:0] splitOk;
  logic       aSplit;
  logic       wrCtrl;
  logic       wrMode;

  assign pinCount = {count_input_b, count_input_a};
  assign pinIrq   = {ext_irq_b_pin, ext_irq_a_pin};
  assign aSplit   = (mode_ff[dual_timer_pkg::NIB_A +: 2] == dual_timer_pkg::MODE_SPLIT);
  assign splitOk  = 2'b01; // Only timer A splits; B mode 3 holds
  assign wrCtrl   = sfrWrite && (sfrAddr == dual_timer_pkg::ADDR_CONTROL);
  assign wrMode   = sfrWrite && (sfrAddr == dual_timer_pkg::ADDR_MODE);

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral cycle divider and pin samplers
  // The divider runs from reset whatever the run bits say, so a unit started
  // at any moment sees its first tick within six clocks. Count pins are seen
  // only on ticks, so a pulse shorter than a peripheral cycle may be missed;
  // interrupt pins are seen on every clock.
  always_comb
  begin
    perTick       = (div_ff == dual_timer_pkg::PER_CYCLE_LAST);
    nxt_div       = perTick ? 3'h0 : div_ff + 3'h1;
    nxt_cntSample = perTick ? pinCount : cntSample_ff;
    nxt_irqSample = pinIrq;
  end

  // Register the divider and samplers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_ff       <= 3'h0;
      cntSample_ff <= 2'h3;
      irqSample_ff <= 2'h3;
    end
    else
    begin
      div_ff       <= nxt_div;
      cntSample_ff <= nxt_cntSample;
      irqSample_ff <= nxt_irqSample;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-unit count enables, count units and register writes
  // Both units share one body; only the nibble, run bit and count addresses differ,
  // plus the mode 3 handling where A splits and B halts.
  for (genvar u = 0; u < 2; u++)
  begin : g_unit
    localparam int NIB = (u == 0) ? dual_timer_pkg::NIB_A : dual_timer_pkg::NIB_B;
    localparam int RUN = (u == 0) ? dual_timer_pkg::BIT_A_RUN : dual_timer_pkg::BIT_B_RUN;
    logic gateOpen;
    logic srcEvent;
    logic runOwn;
    logic halted;
    assign gateOpen = !mode_ff[NIB + dual_timer_pkg::OFS_GATE] || pinIrq[u];
    // Source: every tick as a timer, or a sampled fall of the count pin
    always_comb
    begin
      if (mode_ff[NIB + dual_timer_pkg::OFS_SRC])
      begin
        srcEvent = perTick && cntSample_ff[u] && !pinCount[u];
      end
      else
      begin
        srcEvent = perTick;
      end
    end
    // With A split, B's run bit belongs to A's high byte, so B runs whenever
    // it is out of its own mode 3 and is stopped by moving it into mode 3
    assign runOwn = ctrl_ff[RUN] || (u == 1 && aSplit);
    // Timer B in mode 3 holds its count
    assign halted = (u == 1) && (mode_ff[NIB +: 2] == dual_timer_pkg::MODE_SPLIT);
    assign lowTick[u]  = srcEvent && gateOpen && runOwn && !halted;
    assign highTick[u] = (u == 0) ? (perTick && ctrl_ff[dual_timer_pkg::BIT_B_RUN])
                                  : 1'b0;
    assign wrLow[u]  = sfrWrite && (sfrAddr == ((u == 0) ? dual_timer_pkg::ADDR_A_LOW
                                                         : dual_timer_pkg::ADDR_B_LOW));
    assign wrHigh[u] = sfrWrite && (sfrAddr == ((u == 0) ? dual_timer_pkg::ADDR_A_HIGH
                                                         : dual_timer_pkg::ADDR_B_HIGH));
    // Count bytes and per-mode overflow of this unit
    timer_count_unit u_count (
      .clk          (clk),
      .rst          (rst),
      .lowTick      (lowTick[u]),
      .highTick     (highTick[u]),
      .mode         (mode_ff[NIB +: 2]),
      .splitAllowed (splitOk[u]),
      .wrLow        (wrLow[u]),
      .wrHigh       (wrHigh[u]),
      .wrData       (sfrWrData),
      .countLow     (cntLow[u]),
      .countHigh    (cntHigh[u]),
      .lowOverflow  (lowOvf[u]),
      .highOverflow (highOvf[u])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and mode registers; hardware set wins over any clear
  // Order matters below: software writes first, vector clears next and the
  // hardware sets last, so an event in the clock of a clear is never lost.
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_mode = mode_ff;
    // Software writes take the whole byte, flags included
    if (wrCtrl)
    begin
      nxt_ctrl = sfrWrData;
    end
    if (wrMode)
    begin
      nxt_mode = sfrWrData;
    end
    // Flag clears on vectoring
    if (timerAVectorAck)
    begin
      nxt_ctrl[dual_timer_pkg::BIT_A_OVF] = 1'b0;
    end
    if (timerBVectorAck)
    begin
      nxt_ctrl[dual_timer_pkg::BIT_B_OVF] = 1'b0;
    end
    if (extAVectorAck && ctrl_ff[dual_timer_pkg::BIT_A_TRIG])
    begin
      nxt_ctrl[dual_timer_pkg::BIT_A_EDGE] = 1'b0;
    end
    if (extBVectorAck && ctrl_ff[dual_timer_pkg::BIT_B_TRIG])
    begin
      nxt_ctrl[dual_timer_pkg::BIT_B_EDGE] = 1'b0;
    end
    // Overflow sets; A split routes A high overflow to B's flag
    if (aSplit ? lowOvf[0] : highOvf[0])
    begin
      nxt_ctrl[dual_timer_pkg::BIT_A_OVF] = 1'b1;
    end
    if ((aSplit && highOvf[0]) || highOvf[1])
    begin
      nxt_ctrl[dual_timer_pkg::BIT_B_OVF] = 1'b1;
    end
    // External detection: falling edge or low level per trigger bit
    if (ctrl_ff[dual_timer_pkg::BIT_A_TRIG] ? (irqSample_ff[0] && !pinIrq[0]) : !pinIrq[0])
    begin
      nxt_ctrl[dual_timer_pkg::BIT_A_EDGE] = 1'b1;
    end
    if (ctrl_ff[dual_timer_pkg::BIT_B_TRIG] ? (irqSample_ff[1] && !pinIrq[1]) : !pinIrq[1])
    begin
      nxt_ctrl[dual_timer_pkg::BIT_B_EDGE] = 1'b1;
    end
  end

  // Register control and mode
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_ff <= dual_timer_pkg::RESET_VALUE;
      mode_ff <= dual_timer_pkg::RESET_VALUE;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      mode_ff <= nxt_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data register
  // The count bytes are read one at a time with no shadow latch, so a running
  // 16-bit count can tear; stop the unit first for a coherent pair.
  always_comb
  begin
    nxt_rdData = 8'h00;
    if (sfrRead)
    begin
      case (sfrAddr)
        dual_timer_pkg::ADDR_CONTROL: nxt_rdData = ctrl_ff;
        dual_timer_pkg::ADDR_MODE:    nxt_rdData = mode_ff;
        dual_timer_pkg::ADDR_A_LOW:   nxt_rdData = cntLow[0];
        dual_timer_pkg::ADDR_B_LOW:   nxt_rdData = cntLow[1];
        dual_timer_pkg::ADDR_A_HIGH:  nxt_rdData = cntHigh[0];
        dual_timer_pkg::ADDR_B_HIGH:  nxt_rdData = cntHigh[1];
        default:                      nxt_rdData = 8'h00;
      endcase
    end
  end

  // Register read data; zero when nothing is read
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdData_ff <= 8'h00;
    end
    else
    begin
      rdData_ff <= nxt_rdData;
    end
  end

  // Read port outputs; sfrHit tells the core this block owns the address
  assign sfrRdData = rdData_ff;
  assign sfrHit    = (sfrAddr >= dual_timer_pkg::ADDR_CONTROL)
                     && (sfrAddr <= dual_timer_pkg::ADDR_B_HIGH);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests
  // Timer requests need the flag, the unit enable and the global enable; the
  // external requests are the edge flags themselves, whose clearing depends
  // on the trigger type chosen for each pin.
  always_comb
  begin
    timerAIrq = ctrl_ff[dual_timer_pkg::BIT_A_OVF] && timer_a_irq_enable
                && global_irq_enable;
    timerBIrq = ctrl_ff[dual_timer_pkg::BIT_B_OVF] && timer_b_irq_enable
                && global_irq_enable;
    extAIrq   = ctrl_ff[dual_timer_pkg::BIT_A_EDGE];
    extBIrq   = ctrl_ff[dual_timer_pkg::BIT_B_EDGE];
  end
endmodule : dual_timer_counter_ctrl

// File: testbench/dual_timer_properties.sv
/*
  Port checker for the dual timer block.
  Assumes it is bound to dual_timer_counter_ctrl on one clock.
*/
`timescale 1ns/1ps
module dual_timer_properties (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrRead,
  input wire logic [7:0] sfrRdData,
  input wire logic       sfrHit,
  input wire logic       ext_irq_a_pin,
  input wire logic       global_irq_enable,
  input wire logic       timer_a_irq_enable,
  input wire logic       timer_b_irq_enable,
  input wire logic       timerAVectorAck,
  input wire logic       timerBVectorAck,
  input wire logic       timerAIrq,
  input wire logic       timerBIrq,
  input wire logic       extAIrq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Steps of a stray read and of a vector acknowledge
  sequence strayRead;
    sfrRead && !sfrHit;
  endsequence
  sequence ackA;
    timerAVectorAck;
  endsequence
  sequence ackB;
    timerBVectorAck;
  endsequence
  ////////////////////////////////////////////////////////////////
  irq_a_gate_a: assert property (timerAIrq |-> global_irq_enable && timer_a_irq_enable)
    else $error("timer A request without enables");
  irq_b_gate_a: assert property (timerBIrq |-> global_irq_enable && timer_b_irq_enable)
    else $error("timer B request without enables");
  ack_a_clear_a: assert property (ackA |=> !timerAIrq)
    else $error("timer A flag kept after vector");
  ack_b_clear_a: assert property (ackB |=> !timerBIrq)
    else $error("timer B flag kept after vector");
  stray_read_a: assert property (strayRead |=> sfrRdData == 8'h00)
    else $error("unmapped read returned data");
  idle_data_a: assert property (!sfrRead |=> sfrRdData == 8'h00)
    else $error("read data held past one cycle");
  hit_decode_a: assert property (sfrHit == (sfrAddr >= 8'h88 && sfrAddr <= 8'h8d))
    else $error("address decode wrong");
  reset_clear_a: assert property ($fell(rst) |-> !timerAIrq && !timerBIrq && sfrRdData == 8'h00)
    else $error("outputs not clear after reset");
  ext_low_a: assert property ($rose(extAIrq) |-> !$past(ext_irq_a_pin))
    else $error("external flag set with pin high");
endmodule : dual_timer_properties

bind dual_timer_counter_ctrl dual_timer_properties i_props (
  .clk, .rst, .sfrAddr, .sfrRead, .sfrRdData, .sfrHit, .ext_irq_a_pin,
  .global_irq_enable, .timer_a_irq_enable, .timer_b_irq_enable,
  .timerAVectorAck, .timerBVectorAck, .timerAIrq, .timerBIrq, .extAIrq
);

// File: testbench/core_model.sv
/*
  Processor core stand-in: vectors to pending routines while serving.
  Assumes request levels of order ext B, ext A, timer B, timer A.
*/
`timescale 1ns/1ps
module core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       serve,
  input  wire logic [3:0] irq,
  output logic      [3:0] ack
);
  // One-cycle vector pulse per pending request, then a gap
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack <= 4'h0;
    end
    else
    begin
      ack <= serve ? (irq & ~ack) : 4'h0;
    end
  end
endmodule : core_model

// File: testbench/testbench.sv
/*
  Self-checking bench for the dual timer block.
  Assumes the core model answers requests and a 40 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  logic       clk, rst, sfrWrite, sfrRead, extA, extB, cntA, cntB;
  logic       gie, ieA, ieB, serve, sfrHit, irqA, irqB, eirqA, eirqB;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, rd;
  logic [3:0] ack;
  int         failCount, checksDone, cycles;

  dual_timer_counter_ctrl i_dut (.clk(clk), .rst(rst), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWrData(sfrWrData),
    .sfrRdData(sfrRdData), .sfrHit(sfrHit), .ext_irq_a_pin(extA), .ext_irq_b_pin(extB),
    .count_input_a(cntA), .count_input_b(cntB), .global_irq_enable(gie),
    .timer_a_irq_enable(ieA), .timer_b_irq_enable(ieB), .timerAVectorAck(ack[0]),
    .timerBVectorAck(ack[1]), .extAVectorAck(ack[2]), .extBVectorAck(ack[3]),
    .timerAIrq(irqA), .timerBIrq(irqB), .extAIrq(eirqA), .extBIrq(eirqB));
  core_model i_core (.clk(clk), .rst(rst), .serve(serve),
    .irq({eirqB, eirqA, irqB, irqA}), .ack(ack));
  ////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      failCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrite <= 1'b1;
    @(posedge clk);
    sfrWrite <= 1'b0;
  endtask : wr
  task automatic rd8(logic [7:0] a);
    @(posedge clk);
    sfrAddr <= a;
    sfrRead <= 1'b1;
    @(posedge clk);
    sfrRead <= 1'b0;
    #1 rd = sfrRdData;
  endtask : rd8
  task automatic reg_is(logic [7:0] a, logic [7:0] exp);
    rd8(a);
    check($sformatf("reg %h", a), rd, exp);
  endtask : reg_is
  // Run for exactly n ticks, then clear both run bits, writing back the rest of control as read
  task automatic run_span(logic [7:0] runBits, int n);
    wr(8'h88, runBits);
    repeat (6 * n - 4) @(posedge clk);
    rd8(8'h88);
    wr(8'h88, rd & ~8'h50);
  endtask : run_span
  task automatic serve_all();
    @(posedge clk);
    serve <= 1'b1;
    repeat (4) @(posedge clk);
    serve <= 1'b0;
  endtask : serve_all
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////
  task automatic test_reset();
    for (int a = 8'h88; a <= 8'h8d; a++)
      reg_is(8'(a), 8'h00);
    wr(8'h90, 8'hff);
    reg_is(8'h90, 8'h00);
    check("sfrHit", 8'(sfrHit), 8'h00);
    wr(8'h8c, 8'h5a);
    reg_is(8'h8c, 8'h5a);
    check("sfrHit", 8'(sfrHit), 8'h01);
  endtask : test_reset
  task automatic test_cascade();
    wr(8'h89, 8'h01);
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'hff);
    run_span(8'h10, 2);
    reg_is(8'h8a, 8'h01);
    reg_is(8'h8c, 8'h00);
    reg_is(8'h88, 8'h20);
    ieA <= 1'b1;
    @(posedge clk);
    #1 check("irqA", 8'(irqA), 8'h00);
    gie <= 1'b1;
    @(posedge clk);
    #1 check("irqA", 8'(irqA), 8'h01);
    serve_all();
    reg_is(8'h88, 8'h00);
  endtask : test_cascade
  task automatic test_prescale();
    wr(8'h89, 8'h00);
    wr(8'h8a, 8'h1f);
    wr(8'h8c, 8'h05);
    run_span(8'h10, 2);
    reg_is(8'h8a, 8'h01);
    reg_is(8'h8c, 8'h06);
  endtask : test_prescale
  task automatic test_reload();
    wr(8'h89, 8'h20);
    wr(8'h8b, 8'hff);
    wr(8'h8d, 8'ha0);
    run_span(8'h40, 2);
    reg_is(8'h8b, 8'ha1);
    reg_is(8'h8d, 8'ha0);
    reg_is(8'h88, 8'h80);
    ieB <= 1'b1;
    @(posedge clk);
    #1 check("irqB", 8'(irqB), 8'h01);
    serve_all();
    reg_is(8'h88, 8'h00);
    check("irqB", 8'(irqB), 8'h00);
  endtask : test_reload
  task automatic test_split();
    wr(8'h89, 8'h33);
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'hff);
    run_span(8'h50, 2);
    reg_is(8'h8a, 8'h01);
    reg_is(8'h8c, 8'h01);
    reg_is(8'h88, 8'ha0);
    reg_is(8'h8b, 8'ha1);
    reg_is(8'h8d, 8'ha0);
    serve_all();
  endtask : test_split
  task automatic test_gate();
    wr(8'h89, 8'h09);
    wr(8'h8a, 8'h00);
    extA <= 1'b0;
    run_span(8'h10, 2);
    #1 check("extAIrq", 8'(eirqA), 8'h01);
    reg_is(8'h8a, 8'h00);
    extA <= 1'b1;
    run_span(8'h10, 2);
    reg_is(8'h8a, 8'h02);
  endtask : test_gate
  task automatic test_counter();
    wr(8'h89, 8'hd5);
    wr(8'h8a, 8'h00);
    wr(8'h8b, 8'h10);
    fork
      run_span(8'h50, 4);
      begin
        repeat (12) @(posedge clk);
        cntA <= 1'b0;
        cntB <= 1'b0;
      end
    join
    reg_is(8'h8a, 8'h01);
    reg_is(8'h8b, 8'h11);
    cntA <= 1'b1;
    cntB <= 1'b1;
  endtask : test_counter
  task automatic test_ext_edge();
    wr(8'h88, 8'h04);
    extB <= 1'b0;
    repeat (2) @(posedge clk);
    extB <= 1'b1;
    @(posedge clk);
    #1 check("extBIrq", 8'(eirqB), 8'h01);
    serve_all();
    #1 check("extBIrq", 8'(eirqB), 8'h00);
  endtask : test_ext_edge
  ////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling that cuts a hang short
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failCount++;
      end_of_test();
    end
  end
  // Main sequence
  initial
  begin
    {rst, sfrWrite, sfrRead, gie, ieA, ieB, serve} = 7'h40;
    {extA, extB, cntA, cntB} = 4'hf;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_cascade();
    test_prescale();
    test_reload();
    test_split();
    test_gate();
    test_counter();
    test_ext_edge();
    end_of_test();
  end
endmodule : testbench
